/* hw/sar_map.svh */
// constants for the converter start and parallel readout block
// Contract
// - busy low from start until result stored
// - byte select low gives upper byte
// - select and read/convert ORed; falling select with read/convert low starts
// - result bus driven only when selected and reading
// - result bus 16 bits, bit 15 most significant
// - read/convert falling with select low, idle starts
// - read/convert rising with select low drives bus
// - result coded as two's complement
// - sampler tracks again once conversion ends; start level still low then: code keeps the old sample and restarts
`ifndef SAR_MAP_SVH
`define SAR_MAP_SVH

// ****************************************************************
// timing
// ****************************************************************
`define SAR_CLK_NS 10
`define SAR_T_CONV_NS 2000
`define SAR_T_START_NS 40
`define SAR_RES_W 16
// longest time, rounded down
`define SAR_CONV_CYC ((`SAR_T_CONV_NS) / (`SAR_CLK_NS))
`define SAR_STEP_CYC ((`SAR_CONV_CYC) / (`SAR_RES_W))
`define SAR_START_CYC (((`SAR_T_START_NS) + (`SAR_CLK_NS) - 1) / (`SAR_CLK_NS))

// ****************************************************************
// register map, byte addresses
// ****************************************************************
`define SAR_OFF_CTRL 8'h00
`define SAR_OFF_STATUS 8'h04
`define SAR_OFF_RESULT 8'h08
`define SAR_OFF_COUNT 8'h0C
`define SAR_CTRL_EN 0
`define SAR_CTRL_RST 1'h1
`define SAR_STS_BUSY 0
`define SAR_STS_TRACK 1
`define SAR_STS_STALE 2
`define SAR_RESULT_MSB 15
`define SAR_RESULT_LSB 0
`define SAR_MID_FLIP 16'h8000

`endif

/* hw/sar_pkg.sv */
// types of the converter start and parallel readout block
`default_nettype none
package sar_pkg;
    typedef enum logic [1:0] {
        SAR_IDLE = 2'b00,
        SAR_CONV = 2'b01,
        SAR_UPDT = 2'b10
    } sar_state_t;

    typedef struct packed {
        sar_state_t state;
        logic [3:0] bit_idx;
        logic [7:0] step_cnt;
        logic [15:0] held;
        logic [15:0] approx;
        logic [15:0] result;
        logic [15:0] count;
        logic stale;
        logic done;
    } sar_core_t;

    typedef struct packed {
        logic comb_prev;
    } sar_det_t;

    typedef struct packed {
        logic ack;
        logic [31:0] dat;
        logic en;
    } sar_wb_t;
endpackage : sar_pkg
`default_nettype wire

/* hw/sar_ctl_if.sv */
// control and status between register slave and conversion core
`timescale 1ns/1ps
`default_nettype none
interface sar_ctl_if;
    logic en;
    logic clr_stale;
    logic busy;
    logic track;
    logic stale;
    logic [15:0] result;
    logic [15:0] count;
    modport regs (output en, output clr_stale, input busy, input track, input stale, input result, input count);
    modport core (input en, input clr_stale, output busy, output track, output stale, output result, output count);
endinterface : sar_ctl_if
`default_nettype wire

/* hw/sar_start_det.sv */
// start edge detector and bus enable decode for the host pins
`timescale 1ns/1ps
`default_nettype none
module sar_start_det (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic sel_n_i,
    input wire logic rd_conv_i,
    output logic start_o,
    output logic hold_lvl_o,
    output logic oe_o
);
    import sar_pkg::*;
    sar_det_t s_ff;
    sar_det_t nxt_s;
    logic comb;

    // pins ORed, low level means convert
    assign comb = sel_n_i | rd_conv_i;
    assign hold_lvl_o = ~comb;
    // falling edge of the OR is the start
    assign start_o = s_ff.comb_prev & ~comb;
    // drive only when selected and reading
    assign oe_o = ~sel_n_i & rd_conv_i;

    always_comb
    begin
        nxt_s = s_ff;
        nxt_s.comb_prev = comb;
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            s_ff <= '{comb_prev: 1'b1};
        end
        else
        begin
            s_ff <= nxt_s;
        end
    end
endmodule : sar_start_det
`default_nettype wire

/* hw/sar_wb_regs.sv */
// classic wishbone register slave for the converter block
`timescale 1ns/1ps
`default_nettype none
`include "sar_map.svh"
module sar_wb_regs (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    sar_ctl_if.regs ctl
);
    import sar_pkg::*;
    sar_wb_t s_ff;
    sar_wb_t nxt_s;
    logic commit;

    // writes land on the edge where the master sees ack
    assign commit = wb_cyc_i & wb_stb_i & wb_we_i & s_ff.ack & wb_sel_i[0];
    assign ctl.clr_stale = commit && wb_adr_i == `SAR_OFF_STATUS && wb_dat_i[`SAR_STS_STALE];
    assign ctl.en = s_ff.en;
    assign wb_ack_o = s_ff.ack;
    assign wb_dat_o = s_ff.dat;

    always_comb
    begin
        nxt_s = s_ff;
        nxt_s.ack = wb_cyc_i & wb_stb_i & ~s_ff.ack;
        if (wb_cyc_i && wb_stb_i && !s_ff.ack)
        begin
            // unmapped addresses answer zero
            unique case (wb_adr_i)
                `SAR_OFF_CTRL: nxt_s.dat = {31'h0000_0000, s_ff.en};
                `SAR_OFF_STATUS: nxt_s.dat = {29'h0000_0000, ctl.stale, ctl.track, ctl.busy};
                `SAR_OFF_RESULT: nxt_s.dat = {16'h0000, ctl.result};
                `SAR_OFF_COUNT: nxt_s.dat = {16'h0000, ctl.count};
                default: nxt_s.dat = 32'h0000_0000;
            endcase
        end
        if (commit && wb_adr_i == `SAR_OFF_CTRL)
        begin
            nxt_s.en = wb_dat_i[`SAR_CTRL_EN];
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            s_ff <= '{ack: 1'b0, dat: 32'h0000_0000, en: `SAR_CTRL_RST};
        end
        else
        begin
            s_ff <= nxt_s;
        end
    end
endmodule : sar_wb_regs
`default_nettype wire

/* hw/sar_top.sv */
// converter start control, successive approximation core and parallel readout
`timescale 1ns/1ps
`default_nettype none
`include "sar_map.svh"
module sar_top #(
    parameter int unsigned RES_W = `SAR_RES_W,
    parameter int unsigned STEP_CYC = `SAR_STEP_CYC
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic sel_n_i,
    input wire logic rd_conv_i,
    input wire logic byte_sel_i,
    input wire logic [15:0] sample_i,
    output logic busy_n_o,
    output logic [15:0] result_o,
    output logic [7:0] byte_o,
    output logic result_oe_o
);
    import sar_pkg::*;

    // ****************************************************************
    // elaboration checks
    // ****************************************************************
    if (RES_W != 16)
    begin : g_bad_width
        $error("sar_top: result width must be 16");
    end
    if (STEP_CYC < 1 || STEP_CYC > 256)
    begin : g_bad_step
        $error("sar_top: step length must be 1 to 256 cycles");
    end

    // ****************************************************************
    // submodules
    // ****************************************************************
    sar_ctl_if ctl ();
    sar_core_t s_ff;
    sar_core_t nxt_s;
    logic start;
    logic hold_lvl;
    logic step_end;
    logic go_fresh;
    logic go_stale;
    logic [15:0] trial;

    sar_start_det u_det (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .sel_n_i(sel_n_i),
        .rd_conv_i(rd_conv_i),
        .start_o(start),
        .hold_lvl_o(hold_lvl),
        .oe_o(result_oe_o)
    );

    sar_wb_regs u_regs (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i),
        .wb_adr_i(wb_adr_i),
        .wb_sel_i(wb_sel_i),
        .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o),
        .ctl(ctl)
    );

    // ****************************************************************
    // status toward software
    // ****************************************************************
    assign ctl.busy = s_ff.state != SAR_IDLE;
    assign ctl.track = s_ff.state == SAR_IDLE;
    assign ctl.stale = s_ff.stale;
    assign ctl.result = s_ff.result;
    assign ctl.count = s_ff.count;

    // ****************************************************************
    // host pins
    // ****************************************************************
    // busy low for the whole conversion and update
    assign busy_n_o = s_ff.state == SAR_IDLE;
    // full word straight from the output register
    assign result_o = s_ff.result;
    // byte select low gives the upper byte
    assign byte_o = byte_sel_i ? s_ff.result[7:0] : s_ff.result[`SAR_RESULT_MSB:8];

    // ****************************************************************
    // conversion control
    // ****************************************************************
    // only an idle core accepts a start edge
    assign go_fresh = s_ff.state == SAR_IDLE && start && ctl.en && !s_ff.done;
    // level still low when busy rises: restart on the old sample
    assign go_stale = s_ff.state == SAR_IDLE && s_ff.done && hold_lvl && ctl.en;
    // step divider, one enable pulse per bit decision
    assign step_end = s_ff.step_cnt == 8'(STEP_CYC - 1);
    assign trial = s_ff.approx | (16'h0001 << s_ff.bit_idx);

    always_comb
    begin
        nxt_s = s_ff;
        nxt_s.done = 1'b0;
        // set wins over a software clear in the same cycle
        if (ctl.clr_stale)
        begin
            nxt_s.stale = 1'b0;
        end
        unique case (s_ff.state)
            SAR_IDLE:
            begin
                // sampler tracks the input while idle, except in the cycle of a stale restart
                if (!go_stale)
                begin
                    nxt_s.held = sample_i;
                end
                // start edge from either pin puts the sampler in hold
                if (go_fresh || go_stale)
                begin
                    nxt_s.state = SAR_CONV;
                    nxt_s.bit_idx = 4'hF;
                    nxt_s.step_cnt = 8'h00;
                    nxt_s.approx = 16'h0000;
                end
                if (go_stale)
                begin
                    nxt_s.stale = 1'b1;
                end
            end
            SAR_CONV:
            begin
                nxt_s.step_cnt = step_end ? 8'h00 : 8'(s_ff.step_cnt + 8'h01);
                if (step_end)
                begin
                    // compare in offset binary so the search is monotonic
                    if (trial <= (s_ff.held ^ `SAR_MID_FLIP))
                    begin
                        nxt_s.approx = trial;
                    end
                    if (s_ff.bit_idx == 4'h0)
                    begin
                        nxt_s.state = SAR_UPDT;
                    end
                    else
                    begin
                        nxt_s.bit_idx = 4'(s_ff.bit_idx - 4'h1);
                    end
                end
            end
            SAR_UPDT:
            begin
                nxt_s.result = s_ff.approx ^ `SAR_MID_FLIP;
                nxt_s.count = 16'(s_ff.count + 16'h0001);
                nxt_s.state = SAR_IDLE;
                nxt_s.done = 1'b1;
            end
            default:
            begin
                nxt_s.state = SAR_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            s_ff <= '{state: SAR_IDLE, bit_idx: 4'h0, step_cnt: 8'h00, held: 16'h0000,
                      approx: 16'h0000, result: 16'h0000, count: 16'h0000,
                      stale: 1'b0, done: 1'b0};
        end
        else
        begin
            s_ff <= nxt_s;
        end
    end

    // ****************************************************************
    // checks
    // ****************************************************************
    // helper: length of the current busy low period
    logic [15:0] busy_low_cnt_ff;
    always_ff @(posedge clk_i)
    begin
        if (rst_i || busy_n_o)
        begin
            busy_low_cnt_ff <= 16'h0000;
        end
        else
        begin
            busy_low_cnt_ff <= 16'(busy_low_cnt_ff + 16'h0001);
        end
    end

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    // busy falls right after an accepted start
    chk_busy_on_start: assert property (go_fresh |=> !busy_n_o ##1 !busy_n_o)
        else $error("busy did not fall after start");

    // busy rises only after the update cycle, at full length
    chk_busy_full_len: assert property ($rose(busy_n_o) |->
        $past(s_ff.state) == SAR_UPDT && $past(busy_low_cnt_ff) == 16'(16 * STEP_CYC))
        else $error("busy rose early or late");

    chk_byte_lanes: assert property (byte_o == (byte_sel_i ? result_o[7:0] : result_o[15:8]))
        else $error("wrong byte on byte lanes");

    // falling select with read/convert low starts when idle
    chk_start_by_sel: assert property (busy_n_o && ctl.en && !s_ff.done && !rd_conv_i
        && $fell(sel_n_i) && $past(rd_conv_i) == 1'b0 |=> !busy_n_o)
        else $error("select edge did not start a conversion");

    // bus released unless selected and reading
    chk_bus_hiz: assert property ((sel_n_i || !rd_conv_i) |-> !result_oe_o)
        else $error("result bus driven while deselected");

    // start edges during a conversion are ignored
    chk_busy_ignore: assert property ((s_ff.state == SAR_CONV && s_ff.bit_idx != 4'h0) |=>
        s_ff.state == SAR_CONV && $stable(s_ff.held))
        else $error("conversion disturbed while busy");

    // rising read/convert with select low drives the bus
    chk_bus_drive: assert property (!sel_n_i && $rose(rd_conv_i) |-> result_oe_o ##1 (result_oe_o || !rd_conv_i || sel_n_i))
        else $error("result bus not driven on read");

    // stored code is the held sample in two's complement
    chk_twos_comp: assert property (s_ff.state == SAR_UPDT |=> result_o == $past(s_ff.held) && busy_n_o)
        else $error("result code differs from held sample");

    // sampler tracks the input once back to idle
    chk_track_after: assert property (s_ff.state == SAR_IDLE && !go_stale |=> s_ff.held == $past(sample_i))
        else $error("sampler not tracking while idle");

    chk_result_hold: assert property (s_ff.state != SAR_UPDT |=> $stable(result_o))
        else $error("result changed outside update");

    // ****************************************************************
    // checks: conversion bookkeeping
    // ****************************************************************
    // sample frozen at the start edge
    chk_sample_taken: assert property (go_fresh |=> s_ff.held == $past(sample_i))
        else $error("start edge did not take the sample");

    // sampler stays in hold until idle again
    chk_hold_frozen: assert property (s_ff.state != SAR_IDLE |=> $stable(s_ff.held))
        else $error("held sample moved during conversion");

    // search begins at the top bit
    chk_msb_first: assert property (go_fresh || go_stale |=> s_ff.bit_idx == 4'hF && s_ff.approx == 16'h0000)
        else $error("search did not start at the top bit");

    // no start while the control bit is off
    chk_gated_off: assert property (busy_n_o && !ctl.en |=> busy_n_o)
        else $error("start taken while disabled");

    // a running conversion is never cut short
    chk_busy_no_cut: assert property (s_ff.state == SAR_CONV |=> !busy_n_o)
        else $error("busy released during conversion");

    // busy released right after the update
    chk_upd_release: assert property (s_ff.state == SAR_UPDT |=> busy_n_o && s_ff.done)
        else $error("busy not released after update");

    // selected and reading drives the bus
    chk_bus_enable: assert property (!sel_n_i && rd_conv_i |-> result_oe_o)
        else $error("result bus not driven while read");

    // late release restarts and flags stale
    chk_stale_start: assert property (go_stale |=> !busy_n_o && s_ff.stale)
        else $error("stale restart not flagged");

    // software clear works unless a set collides
    chk_stale_clear: assert property (ctl.clr_stale && !go_stale |=> !s_ff.stale)
        else $error("stale flag not cleared");

    // flag moves only by set or clear
    chk_stale_hold: assert property (!ctl.clr_stale && !go_stale |=> $stable(s_ff.stale))
        else $error("stale flag changed by itself");

    chk_count_step: assert property (s_ff.state == SAR_UPDT |=> s_ff.count - $past(s_ff.count) == 16'h0001)
        else $error("conversion count did not step");

    chk_count_hold: assert property (s_ff.state != SAR_UPDT |=> $stable(s_ff.count))
        else $error("conversion count changed outside update");
endmodule : sar_top
`default_nettype wire

/* sim/sar_host_model.sv */
// host side model driving the converter control pins and the sampled input
`timescale 1ns/1ps
`default_nettype none
module sar_host_model (
    input wire logic clk_i,
    output logic sel_n_o,
    output logic rd_conv_o,
    output logic byte_sel_o,
    output logic [15:0] sample_o
);
    initial
    begin
        sel_n_o = 1'b1;
        rd_conv_o = 1'b1;
        byte_sel_o = 1'b0;
        sample_o = 16'h0000;
    end

    task pins(input logic s, input logic r);
        @(posedge clk_i);
        sel_n_o <= s;
        rd_conv_o <= r;
    endtask : pins

    // one line low first, then the other
    task convert(input logic [15:0] smp, input logic via_sel, input logic bsel, input int hold);
        @(posedge clk_i);
        sample_o <= smp;
        byte_sel_o <= bsel;
        sel_n_o <= via_sel;
        rd_conv_o <= !via_sel;
        @(posedge clk_i);
        sel_n_o <= 1'b0;
        rd_conv_o <= 1'b0;
        // held jointly low for at least 40 ns
        repeat (hold) @(posedge clk_i);
        // input moves on: the held sample must not follow it
        sample_o <= ~smp;
        // both high again after the hold cycles, so a long hold spans the end of busy
        sel_n_o <= 1'b1;
        rd_conv_o <= 1'b1;
    endtask : convert
endmodule : sar_host_model
`default_nettype wire

/* sim/testbench.sv */
// self-checking bench for the converter start and parallel readout block
`timescale 1ns/1ps
`default_nettype none
module testbench;
    localparam int STEP = 1;
    localparam int BUSY_CYC = 16 * STEP + 1;
    logic clk_i, rst_i, wb_cyc, wb_stb, wb_we, wb_ack_o;
    logic [7:0] wb_adr;
    logic [3:0] wb_sel, wr_sel;
    logic [31:0] wb_dat, wb_dat_o, w;
    logic sel_n, rd_conv, byte_sel, busy_n_o, result_oe_o, prev_busy_n;
    logic [15:0] sample, result_o, smp, e;
    logic [7:0] byte_o;
    logic [15:0] exp_res[$];
    logic [31:0] exp_wb[$];
    logic [15:0] tbl [4] = '{16'h7fff, 16'h8000, 16'h0000, 16'hffff};
    int err_count = 0;
    int n_tests = 0;
    int cyc_cnt = 0;
    int lo_cnt = 0;
    int nconv = 0;
    int i;
    integer seed;

    sar_top #(.STEP_CYC(STEP)) sar_top_inst (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
        .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_dat), .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o), .sel_n_i(sel_n), .rd_conv_i(rd_conv), .byte_sel_i(byte_sel), .sample_i(sample),
        .busy_n_o(busy_n_o), .result_o(result_o), .byte_o(byte_o), .result_oe_o(result_oe_o));
    sar_host_model sar_host_model_inst (.clk_i(clk_i), .sel_n_o(sel_n), .rd_conv_o(rd_conv),
        .byte_sel_o(byte_sel), .sample_o(sample));

    initial
    begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end

    task chk(input logic [31:0] seen, input logic [31:0] expv);
        n_tests++;
        if (seen !== expv)
        begin
            err_count++;
            $display("Error at %0t: got %h expected %h", $time, seen, expv);
        end
    endtask : chk

    task summarize();
        if (err_count == 0 && n_tests > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : summarize

    // ****************************************
    // result watcher
    // ****************************************
    always @(posedge clk_i)
    begin
        cyc_cnt++;
        if (cyc_cnt == 4000)
        begin
            err_count++;
            summarize();
        end
        if (busy_n_o === 1'b0)
            lo_cnt++;
        // a reset cuts the busy period short
        if (rst_i !== 1'b0)
            lo_cnt = 0;
        if (rst_i === 1'b0 && busy_n_o === 1'b1 && prev_busy_n === 1'b0)
        begin
            chk(32'(lo_cnt), 32'(BUSY_CYC));
            e = (exp_res.size() > 0) ? exp_res.pop_front() : ~result_o;
            chk(32'(result_o), 32'(e));
            chk(32'(byte_o), 32'(byte_sel ? e[7:0] : e[15:8]));
            lo_cnt = 0;
        end
        prev_busy_n = busy_n_o;
        if (wb_ack_o === 1'b1 && wb_we === 1'b0)
        begin
            w = (exp_wb.size() > 0) ? exp_wb.pop_front() : ~wb_dat_o;
            chk(wb_dat_o, w);
        end
    end

    task wb(input logic we, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_i);
        wb_cyc <= 1'b1;
        wb_stb <= 1'b1;
        wb_we <= we;
        wb_adr <= a;
        wb_sel <= wr_sel;
        wb_dat <= d;
        do
        begin
            @(posedge clk_i);
            n++;
        end
        while (wb_ack_o !== 1'b1 && n < 50);
        if (wb_ack_o !== 1'b1)
        begin
            err_count++;
            summarize();
        end
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
        wb_we <= 1'b0;
    endtask : wb

    task rd(input logic [7:0] a, input logic [31:0] expv);
        exp_wb.push_back(expv);
        wb(1'b0, a, 32'h0000_0000);
    endtask : rd

    task wait_idle();
        int n;
        n = 0;
        while (busy_n_o !== 1'b1 && n < 200)
        begin
            @(posedge clk_i);
            n++;
        end
        if (busy_n_o !== 1'b1)
        begin
            err_count++;
            summarize();
        end
        repeat (2) @(posedge clk_i);
    endtask : wait_idle

    // ****************************************
    // main sequence
    // ****************************************
    initial
    begin
        seed = 5435;
        rst_i = 1'b1;
        wb_cyc = 1'b0;
        wb_stb = 1'b0;
        wb_we = 1'b0;
        wb_adr = 8'h00;
        wb_sel = 4'hf;
        wr_sel = 4'hf;
        wb_dat = 32'h0000_0000;
        repeat (12) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        #1;
        chk(32'(busy_n_o), 32'h0000_0001);
        chk(32'(result_o), 32'h0000_0000);
        rd(8'h00, 32'h0000_0001);
        rd(8'h04, 32'h0000_0002);
        rd(8'h10, 32'h0000_0000);
        // writes without the low byte lane are ignored
        wr_sel = 4'he;
        wb(1'b1, 8'h00, 32'h0000_0000);
        wr_sel = 4'hf;
        rd(8'h00, 32'h0000_0001);
        // pin combos never form a falling edge of the ORed start
        for (i = 0; i < 3; i++)
        begin
            sar_host_model_inst.pins(i != 2, i != 1);
            #1;
            chk(32'(result_oe_o), 32'(i == 2));
        end
        sar_host_model_inst.pins(1'b1, 1'b1);
        for (i = 0; i < 8; i++)
        begin
            smp = (i < 4) ? tbl[i] : 16'($random(seed));
            exp_res.push_back(smp);
            nconv++;
            sar_host_model_inst.convert(smp, i[0], i[1], 4);
            wait_idle();
        end
        rd(8'h08, 32'(smp));
        rd(8'h0C, 32'(nconv));
        // a second start while busy is ignored
        smp = 16'($random(seed));
        exp_res.push_back(smp);
        nconv++;
        sar_host_model_inst.convert(smp, 1'b0, 1'b0, 4);
        sar_host_model_inst.convert(~smp, 1'b1, 1'b1, 4);
        wait_idle();
        // starts gated off through the control register
        wb(1'b1, 8'h00, 32'h0000_0000);
        sar_host_model_inst.convert(16'h1234, 1'b0, 1'b0, 4);
        wait_idle();
        chk(32'(busy_n_o), 32'h0000_0001);
        rd(8'h0C, 32'(nconv));
        wb(1'b1, 8'h00, 32'h0000_0001);
        // start held low across the end of busy: restart on the old sample
        smp = 16'($random(seed));
        exp_res.push_back(smp);
        exp_res.push_back(smp);
        nconv += 2;
        sar_host_model_inst.convert(smp, 1'b1, 1'b0, 22);
        wait_idle();
        rd(8'h04, 32'h0000_0006);
        wb(1'b1, 8'h04, 32'h0000_0004);
        rd(8'h04, 32'h0000_0002);
        rd(8'h0C, 32'(nconv));
        // reset cut into a running conversion
        sar_host_model_inst.convert(16'h5a5a, 1'b0, 1'b1, 4);
        rst_i <= 1'b1;
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        #1;
        chk(32'(busy_n_o), 32'h0000_0001);
        chk(32'(result_o), 32'h0000_0000);
        rd(8'h0C, 32'h0000_0000);
        rd(8'h04, 32'h0000_0002);
        smp = 16'($random(seed));
        exp_res.push_back(smp);
        sar_host_model_inst.convert(smp, 1'b1, 1'b1, 4);
        wait_idle();
        rd(8'h08, 32'(smp));
        rd(8'h0C, 32'h0000_0001);
        repeat (4) @(posedge clk_i);
        chk(32'(exp_res.size() + exp_wb.size()), 32'h0000_0000);
        summarize();
    end
endmodule : testbench
`default_nettype wire
